/* rtl/tcc_channels.v */
// timer core: kernel clock counter, slave controller, two capture/compare channels
// assumes pins synchronous-ish inputs and a host register port with read data one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.vh"

module tcc_channels (
   input wire sys_clk,
   input wire rst,
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire [1:0] timer_input_pin,
   output reg [1:0] channel_out,
   output reg [1:0] reference_waveform,
   output wire [1:0] channel_irq,
   output wire [1:0] channel_dma_req,
   output reg [15:0] count
);

   // ==========================================
   // decode helpers
   // ==========================================
   // filter code to required consecutive samples
   function [4:0] tcc_flt_len;
      input [3:0] code;
      begin
         case (code)
            4'h0: tcc_flt_len = 5'h01;
            4'h1: tcc_flt_len = 5'h02;
            4'h2: tcc_flt_len = 5'h04;
            4'h3: tcc_flt_len = 5'h08;
            4'h4: tcc_flt_len = 5'h06;
            4'h5: tcc_flt_len = 5'h08;
            4'h6: tcc_flt_len = 5'h06;
            4'h7: tcc_flt_len = 5'h08;
            default: tcc_flt_len = 5'h08;
         endcase
      end
   endfunction

   function [3:0] tcc_psc_len;
      input [1:0] code;
      begin
         tcc_psc_len = (4'h1 << code) - 4'h1;
      end
   endfunction

   // ==========================================
   // registers
   // ==========================================
   reg run, dir, counting_down;
   reg [2:0] slave_mode_select;
   reg [2:0] trigger_select;
   reg [11:0] chcfg [0:1];
   reg [7:0] enable_bits;
   reg [15:0] psc_pre, psc_act, psc_cnt, reload_pre;
   reg [15:0] ccr_pre [0:1];
   reg [15:0] ccr_shadow [0:1];
   reg update_flag, trigger_flag;
   reg [1:0] channel_flag, over_capture_flag;
   reg [3:0] dts_cnt;
   wire dts_tick = (dts_cnt == `TCC_DTS_DIV - 4'h1);

   wire wr_ctrl = reg_wr && (reg_addr == `TCC_A_CTRL);
   wire wr_ev = reg_wr && (reg_addr == `TCC_A_EVENT);
   wire wr_st = reg_wr && (reg_addr == `TCC_A_STATUS);
   wire update_generate = wr_ev && reg_wdata[`TCC_EV_UPD];

   // ==========================================
   // input stage per channel
   // ==========================================
   reg [1:0] sync1, sync2;
   reg [1:0] filtered_input;
   wire [1:0] edge_rise, edge_fall;
   reg [1:0] filt_prev;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync1 <= 2'h0;
         sync2 <= 2'h0;
      end else begin
         sync1 <= timer_input_pin;
         sync2 <= sync1;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst)
         dts_cnt <= 4'h0;
      else if (dts_tick)
         dts_cnt <= 4'h0;
      else
         dts_cnt <= dts_cnt + 4'h1;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_in
         reg [4:0] run_len;
         // code 0000 passes on one sample
         always @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               run_len <= 5'h0;
               filtered_input[gi] <= 1'b0;
            end else if (sync2[gi] == filtered_input[gi]) begin
               run_len <= 5'h0;
            end else if (dts_tick) begin
               if (run_len + 5'h1 >= tcc_flt_len(chcfg[gi][`TCC_CH_FLT_LSB +: 4])) begin
                  filtered_input[gi] <= sync2[gi];
                  run_len <= 5'h0;
               end else begin
                  run_len <= run_len + 5'h1;
               end
            end
         end
         assign edge_rise[gi] = filtered_input[gi] & ~filt_prev[gi];
         assign edge_fall[gi] = ~filtered_input[gi] & filt_prev[gi];
      end
   endgenerate

   always @(posedge sys_clk or posedge rst) begin
      if (rst)
         filt_prev <= 2'h0;
      else
         filt_prev <= filtered_input;
   end

   wire [1:0] pol = {enable_bits[4 + `TCC_EN_POL], enable_bits[`TCC_EN_POL]};
   // edge_selected_input[src] as seen with polarity of channel ch
   function tcc_edge;
      input src;
      input p;
      input [1:0] r;
      input [1:0] f;
      begin
         tcc_edge = p ? f[src] : r[src];
      end
   endfunction
   wire [1:0] edge_selected_input;
   assign edge_selected_input[0] = tcc_edge(1'b0, pol[0], edge_rise, edge_fall);
   assign edge_selected_input[1] = tcc_edge(1'b1, pol[1], edge_rise, edge_fall);

   // ==========================================
   // slave controller
   // ==========================================
   // 110 picks channel 2
   // only own channel inputs reach trigger
   wire trig_edge = (trigger_select == `TCC_TS_CH2) ? edge_selected_input[1] :
                    (trigger_select == `TCC_TS_CH1) ? edge_selected_input[0] : 1'b0;
   wire ext_mode = (slave_mode_select == `TCC_SMS_EXT1);
   wire reset_mode = (slave_mode_select == `TCC_SMS_RESET);
   wire trig_event = trig_edge && (ext_mode || reset_mode);

   // internal clock, or trigger edges in external clock mode, through prescaler once running
   wire psc_tick = run && (ext_mode ? trig_edge : 1'b1);
   wire cnt_step = psc_tick && (psc_cnt == psc_act);
   wire overflow = cnt_step && (dir ? (count == 16'h0) : (count == reload_pre));
   wire do_update = overflow || update_generate || (reset_mode && trig_edge);

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count <= 16'h0;
         psc_cnt <= 16'h0;
         psc_act <= 16'h0;
         counting_down <= 1'b0;
      end else begin
         counting_down <= dir;
         if (reg_wr && reg_addr == `TCC_A_COUNT)
            count <= reg_wdata[15:0];
         else if (update_generate || (reset_mode && trig_edge)) begin
            count <= dir ? reload_pre : 16'h0;
            psc_cnt <= 16'h0;
            psc_act <= psc_pre;
         end else if (psc_tick) begin
            if (cnt_step) begin
               psc_cnt <= 16'h0;
               if (overflow) begin
                  count <= dir ? reload_pre : 16'h0;
                  psc_act <= psc_pre;
               end else
                  count <= dir ? count - 16'h1 : count + 16'h1;
            end else
               psc_cnt <= psc_cnt + 16'h1;
         end
      end
   end

   // ==========================================
   // capture / compare channels
   // ==========================================
   wire rd_st = reg_rd && (reg_addr == `TCC_A_STATUS);
   wire [1:0] ev_ch = wr_ev ? {reg_wdata[`TCC_EV_CH2], reg_wdata[`TCC_EV_CH1]} : 2'h0;
   wire [1:0] capt_evt;
   wire [1:0] cmp_hit;
   wire [1:0] flag_set;

   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
         wire [1:0] sel = chcfg[gi][`TCC_CH_SEL_LSB +: 2];
         wire [2:0] om = chcfg[gi][`TCC_CH_OM_LSB +: 3];
         wire is_in = (sel != `TCC_SEL_OUT);
         wire en = enable_bits[4 * gi + `TCC_EN_CH];
         // own input; input 1 for channel 2
         wire own_idx = (gi == 1);
         wire src_edge = (sel == `TCC_SEL_OWN) ? tcc_edge(own_idx, pol[gi], edge_rise, edge_fall) :
                         (sel == `TCC_SEL_OTHER) ? tcc_edge(~own_idx, pol[gi], edge_rise, edge_fall) : 1'b0;
         reg [3:0] ps_cnt;
         wire ps_hit = (ps_cnt == tcc_psc_len(chcfg[gi][`TCC_CH_PSC_LSB +: 2]));
         assign capt_evt[gi] = is_in && en && src_edge && ps_hit;
         assign cmp_hit[gi] = !is_in && cnt_step && (count == ccr_shadow[gi]);
         assign flag_set[gi] = capt_evt[gi] || cmp_hit[gi] || ev_ch[gi];
         wire rd_ccr = reg_rd && (reg_addr == `TCC_A_CCR1 + gi);
         wire wr_ccr = reg_wr && (reg_addr == `TCC_A_CCR1 + gi);

         always @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               ps_cnt <= 4'h0;
               ccr_pre[gi] <= 16'h0;
               ccr_shadow[gi] <= 16'h0;
               channel_flag[gi] <= 1'b0;
               over_capture_flag[gi] <= 1'b0;
               reference_waveform[gi] <= 1'b0;
               channel_out[gi] <= 1'b0;
            end else begin
               if (!is_in || !en)
                  ps_cnt <= 4'h0;
               else if (src_edge)
                  ps_cnt <= ps_hit ? 4'h0 : ps_cnt + 4'h1;
               if (capt_evt[gi]) begin
                  ccr_shadow[gi] <= count;
                  ccr_pre[gi] <= count;
               end else if (wr_ccr && !is_in) begin
                  ccr_pre[gi] <= reg_wdata[15:0];
               end else if (!is_in && do_update) begin
                  ccr_shadow[gi] <= ccr_pre[gi];
               end
               if ((capt_evt[gi] || ev_ch[gi]) && channel_flag[gi])
                  over_capture_flag[gi] <= 1'b1;
               else if (wr_st && !reg_wdata[`TCC_ST_OVR1 + gi])
                  over_capture_flag[gi] <= 1'b0;
               // clear by write 0 or data read; set wins
               if (flag_set[gi])
                  channel_flag[gi] <= 1'b1;
               else if ((wr_st && !reg_wdata[`TCC_ST_CH1 + gi]) || rd_ccr)
                  channel_flag[gi] <= 1'b0;
               case (om)
                  `TCC_OM_HIGH: reference_waveform[gi] <= 1'b1;
                  `TCC_OM_LOW: reference_waveform[gi] <= 1'b0;
                  `TCC_OM_SET: if (cmp_hit[gi]) reference_waveform[gi] <= 1'b1;
                  `TCC_OM_CLR: if (cmp_hit[gi]) reference_waveform[gi] <= 1'b0;
                  `TCC_OM_TOG: if (cmp_hit[gi]) reference_waveform[gi] <= ~reference_waveform[gi];
                  default: reference_waveform[gi] <= reference_waveform[gi];
               endcase
               channel_out[gi] <= (is_in || !en) ? 1'b0 : (reference_waveform[gi] ^ pol[gi]);
            end
         end
         assign channel_irq[gi] = channel_flag[gi] && enable_bits[4 * gi + `TCC_EN_IRQ];
         assign channel_dma_req[gi] = channel_flag[gi] && enable_bits[4 * gi + `TCC_EN_DMA];
      end
   endgenerate

   // ==========================================
   // register writes and status flags
   // ==========================================
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         run <= 1'b0;
         dir <= 1'b0;
         slave_mode_select <= `TCC_SMS_OFF;
         trigger_select <= 3'h0;
         chcfg[0] <= 12'h0;
         chcfg[1] <= 12'h0;
         enable_bits <= 8'h0;
         psc_pre <= 16'h0;
         reload_pre <= `TCC_RELOAD_RST;
         update_flag <= 1'b0;
         trigger_flag <= 1'b0;
      end else begin
         // only software changes run and direction
         if (wr_ctrl) begin
            run <= reg_wdata[`TCC_CTRL_RUN];
            dir <= reg_wdata[`TCC_CTRL_DIR];
         end
         if (reg_wr && reg_addr == `TCC_A_SLAVE) begin
            slave_mode_select <= reg_wdata[`TCC_SMS_LSB +: 3];
            trigger_select <= reg_wdata[`TCC_TS_LSB +: 3];
         end
         if (reg_wr && reg_addr == `TCC_A_CHCFG1)
            chcfg[0] <= reg_wdata[11:0];
         if (reg_wr && reg_addr == `TCC_A_CHCFG2)
            chcfg[1] <= reg_wdata[11:0];
         if (reg_wr && reg_addr == `TCC_A_ENABLE)
            enable_bits <= reg_wdata[7:0];
         if (reg_wr && reg_addr == `TCC_A_PSC)
            psc_pre <= reg_wdata[15:0];
         if (reg_wr && reg_addr == `TCC_A_RELOAD)
            reload_pre <= reg_wdata[15:0];
         if (do_update)
            update_flag <= 1'b1;
         else if (wr_st && !reg_wdata[`TCC_ST_UPD])
            update_flag <= 1'b0;
         if (trig_event || (wr_ev && reg_wdata[`TCC_EV_TRG]))
            trigger_flag <= 1'b1;
         else if (wr_st && !reg_wdata[`TCC_ST_TRG])
            trigger_flag <= 1'b0;
      end
   end

   // ==========================================
   // read port
   // ==========================================
   // reads return preload copies
   always @(posedge sys_clk or posedge rst) begin
      if (rst)
         reg_rdata <= 32'h0;
      else if (reg_rd) begin
         case (reg_addr)
            `TCC_A_CTRL: reg_rdata <= {30'h0, dir, run};
            `TCC_A_SLAVE: reg_rdata <= {25'h0, trigger_select, 1'b0, slave_mode_select};
            `TCC_A_CHCFG1: reg_rdata <= {20'h0, chcfg[0]};
            `TCC_A_CHCFG2: reg_rdata <= {20'h0, chcfg[1]};
            `TCC_A_ENABLE: reg_rdata <= {24'h0, enable_bits};
            `TCC_A_STATUS: reg_rdata <= {21'h0, over_capture_flag, 2'h0, trigger_flag, 3'h0,
                                         channel_flag, update_flag};
            `TCC_A_COUNT: reg_rdata <= {16'h0, count};
            `TCC_A_PSC: reg_rdata <= {16'h0, psc_pre};
            `TCC_A_RELOAD: reg_rdata <= {16'h0, reload_pre};
            `TCC_A_CCR1: reg_rdata <= {16'h0, ccr_pre[0]};
            `TCC_A_CCR2: reg_rdata <= {16'h0, ccr_pre[1]};
            default: reg_rdata <= 32'h0;
         endcase
      end
   end

endmodule
`default_nettype wire

/* rtl/tcc_regs.vh */
// register map, field positions, reset values and timing counts for the timer capture/compare block
// assumes a single 200 MHz kernel clock and the plain register port of the host
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

// word addresses on the register port
`define TCC_A_CTRL 4'h0
`define TCC_A_SLAVE 4'h1
`define TCC_A_CHCFG1 4'h2
`define TCC_A_CHCFG2 4'h3
`define TCC_A_ENABLE 4'h4
`define TCC_A_STATUS 4'h5
`define TCC_A_EVENT 4'h6
`define TCC_A_COUNT 4'h7
`define TCC_A_PSC 4'h8
`define TCC_A_RELOAD 4'h9
`define TCC_A_CCR1 4'ha
`define TCC_A_CCR2 4'hb

// ctrl fields
`define TCC_CTRL_RUN 0
`define TCC_CTRL_DIR 1
// slave fields
`define TCC_SMS_LSB 0
`define TCC_TS_LSB 4
// channel config fields
`define TCC_CH_SEL_LSB 0
`define TCC_CH_PSC_LSB 2
`define TCC_CH_FLT_LSB 4
`define TCC_CH_OM_LSB 8
// enable fields, per channel n: base + 4*n
`define TCC_EN_CH 0
`define TCC_EN_POL 1
`define TCC_EN_IRQ 2
`define TCC_EN_DMA 3
// status fields
`define TCC_ST_UPD 0
`define TCC_ST_CH1 1
`define TCC_ST_CH2 2
`define TCC_ST_TRG 6
`define TCC_ST_OVR1 9
`define TCC_ST_OVR2 10
// event fields
`define TCC_EV_UPD 0
`define TCC_EV_CH1 1
`define TCC_EV_CH2 2
`define TCC_EV_TRG 6

// mode codes
`define TCC_SMS_OFF 3'h0
`define TCC_SMS_RESET 3'h4
`define TCC_SMS_EXT1 3'h7
`define TCC_TS_CH1 3'h5
`define TCC_TS_CH2 3'h6
`define TCC_SEL_OUT 2'h0
`define TCC_SEL_OWN 2'h1
`define TCC_SEL_OTHER 2'h2
`define TCC_OM_LOW 3'h4
`define TCC_OM_HIGH 3'h5
`define TCC_OM_FROZEN 3'h0
`define TCC_OM_SET 3'h1
`define TCC_OM_CLR 3'h2
`define TCC_OM_TOG 3'h3
`define TCC_OM_PWM1 3'h6
`define TCC_OM_PWM2 3'h7

`define TCC_RELOAD_RST 16'hffff
// dead-time sampling rate = kernel clock / this
`define TCC_DTS_DIV 4'h1

`endif

/* verif/tcc_pin_src.sv */
// far side of the timer pins: a digital source that drives both timer inputs
// assumes the bench calls its tasks one at a time; levels change at rising edges
`timescale 1ns/1ps
`default_nettype none

module tcc_pin_src (
   input wire logic sys_clk,
   output logic [1:0] pin
);
   initial pin = 2'b00;

   // ==========================================
   // pin waveforms
   task automatic pulse(input int ch, input int hi, input int lo);
      @(posedge sys_clk) pin[ch] <= 1'b1;
      repeat (hi) @(posedge sys_clk);
      pin[ch] <= 1'b0;
      repeat (lo) @(posedge sys_clk);
   endtask

   task automatic level(input int ch, input logic v);
      @(posedge sys_clk) pin[ch] <= v;
   endtask
endmodule
`default_nettype wire

/* verif/tcc_channels_props.sv */
// concurrent checks on the ports of the timer capture/compare block
// assumes one clock domain; host writes are mirrored here to know the mode
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.vh"

module tcc_props (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [1:0] timer_input_pin,
   input wire logic [1:0] channel_out,
   input wire logic [1:0] reference_waveform,
   input wire logic [1:0] channel_irq,
   input wire logic [1:0] channel_dma_req,
   input wire logic [15:0] count
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // ==========================================
   // mirror of configuration written by the host
   logic [31:0] ctl, slv, cfg1, cfg2, en;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctl <= '0;
         slv <= '0;
         cfg1 <= '0;
         cfg2 <= '0;
         en <= '0;
      end else if (reg_wr) begin
         if (reg_addr == `TCC_A_CTRL) ctl <= reg_wdata;
         if (reg_addr == `TCC_A_SLAVE) slv <= reg_wdata;
         if (reg_addr == `TCC_A_CHCFG1) cfg1 <= reg_wdata;
         if (reg_addr == `TCC_A_CHCFG2) cfg2 <= reg_wdata;
         if (reg_addr == `TCC_A_ENABLE) en <= reg_wdata;
      end
   end
   logic forced1, ext2;
   assign forced1 = cfg1[1:0] == `TCC_SEL_OUT && en[0];
   assign ext2 = ctl[0] && slv[2:0] == `TCC_SMS_EXT1 && slv[6:4] == `TCC_TS_CH2 && cfg2[7:0] == 8'h01;

   // ==========================================
   // assertions
   property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without a read");
   property p_unmapped; reg_rd && reg_addr > `TCC_A_CCR2 |=> reg_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_evt_rd; reg_rd && reg_addr == `TCC_A_EVENT |=> reg_rdata[2:0] == 3'h0; endproperty
   a_evt_rd: assert property (p_evt_rd) else $error("event bits did not self clear");
   property p_rd_clr; reg_rd && reg_addr == `TCC_A_CCR1 |=> !channel_irq[0]; endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("capture read left flag set");
   property p_wr_clr;
      reg_wr && reg_addr == `TCC_A_STATUS && !reg_wdata[`TCC_ST_CH1] |=> !channel_irq[0] && !channel_dma_req[0];
   endproperty
   a_wr_clr: assert property (p_wr_clr) else $error("write zero left flag set");
   property p_force_hi;
      (forced1 && cfg1[10:8] == `TCC_OM_HIGH && $stable(en))[*3] |-> reference_waveform[0] && channel_out[0] == !en[1];
   endproperty
   a_force_hi: assert property (p_force_hi) else $error("forced high level wrong");
   property p_force_lo;
      (forced1 && cfg1[10:8] == `TCC_OM_LOW && $stable(en))[*3] |-> !reference_waveform[0] && channel_out[0] == en[1];
   endproperty
   a_force_lo: assert property (p_force_lo) else $error("forced low level wrong");
   property p_ext;
      ext2 && (en[5] ? $fell(timer_input_pin[1]) : $rose(timer_input_pin[1])) |-> ##[2:6] count != $past(count);
   endproperty
   a_ext: assert property (p_ext) else $error("edge did not step the counter");
   property p_evt_irq; reg_wr && reg_addr == `TCC_A_EVENT && reg_wdata[2] && en[6] |=> channel_irq[1]; endproperty
   a_evt_irq: assert property (p_evt_irq) else $error("event generate gave no request");
endmodule

bind tcc_channels tcc_props u_props (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_input_pin(timer_input_pin),
   .channel_out(channel_out), .reference_waveform(reference_waveform), .channel_irq(channel_irq),
   .channel_dma_req(channel_dma_req), .count(count));
`default_nettype wire

/* verif/timer_capture_compare_channels_test.sv */
// self-checking bench for the timer capture/compare block
// assumes the pin source model and the port checker bound to the design
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.vh"

module timer_capture_compare_channels_test;
   logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic [1:0] pin, channel_out, reference_waveform, channel_irq, channel_dma_req;
   logic [15:0] count;
   int failures = 0, n_compared = 0, cyc = 0, n, h, l, v;

   always #2.5 sys_clk = ~sys_clk;

   tcc_channels dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_input_pin(pin), .channel_out(channel_out),
      .reference_waveform(reference_waveform), .channel_irq(channel_irq), .channel_dma_req(channel_dma_req),
      .count(count));
   tcc_pin_src u_pins (.sys_clk(sys_clk), .pin(pin));

   // ==========================================
   // host port and comparisons
   task automatic wr(input logic [3:0] a, input logic [31:0] w);
      @(posedge sys_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= w; end
      @(posedge sys_clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
      @(posedge sys_clk) reg_rd <= 1'b0;
      // take the data half a cycle after it is loaded, clear of the launching edge
      @(negedge sys_clk) d = reg_rdata;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // pwm measurements may sit up to two counts off, depending on where the reset lands
   task automatic near(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if ((g + 32'h2 >= e && g <= e + 32'h2) !== 1'b1) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard, well above the roughly 1200 cycles the sequence needs at most
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         final_report;
      end
   end

   // ==========================================
   // main sequence
   initial begin
      void'($urandom(41));
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      rd(`TCC_A_STATUS); cmp("status reset", 32'h0, d);
      rd(4'hc); cmp("unmapped", 32'h0, d);
      rd(`TCC_A_RELOAD); cmp("reload reset", {16'h0, `TCC_RELOAD_RST}, d);
      wr(`TCC_A_CTRL, 32'h1);
      wr(`TCC_A_EVENT, 32'h1);
      rd(`TCC_A_EVENT); cmp("update self clear", 32'h0, d & 32'h7);
      rd(`TCC_A_COUNT); cmp("internal counting", 32'h1, {31'h0, d[15:0] != 16'h0});
      wr(`TCC_A_CHCFG1, {30'h0, `TCC_SEL_OWN});
      wr(`TCC_A_CCR1, 32'h1234);
      rd(`TCC_A_CCR1); cmp("ccr1 read only", 32'h0, d);
      u_pins.pulse(0, 4, 12);
      rd(`TCC_A_STATUS); cmp("no capture disabled", 32'h0, d & 32'h2);
      wr(`TCC_A_ENABLE, 32'h5);
      u_pins.pulse(0, 4, 12);
      cmp("capture irq", 32'h1, {31'h0, channel_irq[0]});
      rd(`TCC_A_CCR1); cmp("capture latched", 32'h1, {31'h0, d != 32'h0});
      cmp("read clears flag", 32'h0, {31'h0, channel_irq[0]});
      u_pins.pulse(0, 4, 12);
      u_pins.pulse(0, 4, 12);
      rd(`TCC_A_STATUS); cmp("overcapture", 32'h202, d & 32'h202);
      rd(`TCC_A_CCR1);
      rd(`TCC_A_STATUS); cmp("over stays after read", 32'h200, d & 32'h202);
      wr(`TCC_A_STATUS, 32'h0);
      rd(`TCC_A_STATUS); cmp("write zero clears", 32'h0, d & 32'h202);
      wr(`TCC_A_CHCFG1, 32'h31);
      u_pins.pulse(0, 5, 16);
      rd(`TCC_A_STATUS); cmp("glitch filtered", 32'h0, d & 32'h2);
      u_pins.pulse(0, 12, 16);
      rd(`TCC_A_STATUS); cmp("long pulse passes", 32'h2, d & 32'h2);
      wr(`TCC_A_CHCFG1, {30'h0, `TCC_SEL_OWN});
      // external clock on the channel-2 input, both edge polarities
      for (int p = 0; p < 2; p++) begin
         wr(`TCC_A_CHCFG2, {30'h0, `TCC_SEL_OWN});
         wr(`TCC_A_ENABLE, 32'h15 | (p << 5));
         wr(`TCC_A_SLAVE, {`TCC_TS_CH2, 1'b0, `TCC_SMS_EXT1});
         wr(`TCC_A_COUNT, 32'h0);
         wr(`TCC_A_STATUS, 32'h0);
         n = $urandom_range(3, 9);
         repeat (n) u_pins.pulse(1, 3, 4);
         u_pins.level(1, 1'b1);
         repeat (8) @(posedge sys_clk);
         rd(`TCC_A_COUNT); cmp("edge count", n + (p == 0), d);
         rd(`TCC_A_STATUS); cmp("trigger flag", 32'h40, d & 32'h40);
         u_pins.level(1, 1'b0);
         repeat (8) @(posedge sys_clk);
      end
      wr(`TCC_A_SLAVE, 32'h0);
      wr(`TCC_A_ENABLE, 32'hd0);
      wr(`TCC_A_STATUS, 32'h0);
      wr(`TCC_A_EVENT, 32'h4);
      @(negedge sys_clk);
      cmp("event dma", 32'h3, {30'h0, channel_dma_req[1], channel_irq[1]});
      // pwm input measurement on the channel-1 pin
      h = $urandom_range(10, 40);
      l = $urandom_range(10, 40);
      wr(`TCC_A_CHCFG2, {30'h0, `TCC_SEL_OTHER});
      wr(`TCC_A_ENABLE, 32'h31);
      wr(`TCC_A_SLAVE, {`TCC_TS_CH1, 1'b0, `TCC_SMS_RESET});
      repeat (3) u_pins.pulse(0, h, l);
      rd(`TCC_A_CCR1); near("pwm period", h + l, d);
      rd(`TCC_A_CCR2); near("pwm duty", h, d);
      // forced outputs, compare still running
      wr(`TCC_A_SLAVE, 32'h0);
      wr(`TCC_A_CHCFG1, {`TCC_OM_HIGH, 8'h0});
      wr(`TCC_A_ENABLE, 32'h1);
      repeat (4) @(posedge sys_clk);
      cmp("force high", 32'h3, {30'h0, reference_waveform[0], channel_out[0]});
      wr(`TCC_A_ENABLE, 32'h7);
      repeat (4) @(posedge sys_clk);
      cmp("force high inverted", 32'h2, {30'h0, reference_waveform[0], channel_out[0]});
      wr(`TCC_A_CHCFG1, {`TCC_OM_LOW, 8'h0});
      repeat (4) @(posedge sys_clk);
      cmp("force low inverted", 32'h1, {30'h0, reference_waveform[0], channel_out[0]});
      v = $urandom_range(100, 500);
      wr(`TCC_A_CCR1, v);
      wr(`TCC_A_EVENT, 32'h1);
      wr(`TCC_A_STATUS, 32'h0);
      repeat (v + 20) @(posedge sys_clk);
      rd(`TCC_A_STATUS); cmp("forced compare flag", 32'h2, d & 32'h2);
      cmp("forced compare irq", 32'h1, {31'h0, channel_irq[0]});
      final_report;
   end
endmodule
`default_nettype wire
